/* File: src/pcd_pkg.sv */
// Constants, field layout and state encoding for the parity control and decode block.
// Contract
// - Unused bits read zero, writes ignored
// - Enabled errors drive data lines 16, 17
// - Report enable bit is writable, reset clears
// - Force bit writes wrong parity to memory
// - Force bit is writable, reset clears
// - Error captures address 11-17 and 18-21
// - Extended read shows bits 18-21 at 5-8
// - Otherwise field shows stored or captured address
// - Address field writable, kept through reset
// - Newest error overwrites stored address
// - Capture resolves to one kiloword segment
// - Read parity error sets bit 15
// - Bit 15 writable, reset clears
// - Start straps pick 4 kiloword boundary
// - High start needs extended addressing both ends
// - Size is sum of two strap groups
// - Register at one of eight strapped addresses
// - Register needs enable in, disable out
// - Inhibit strap blocks data line 17
// - Parity generated and checked per byte
// - Bank select deselects memory, qualifies register
package pcd_pkg;
  // Register bit positions.
  localparam int BIT_EN = 0;
  localparam int BIT_WWP = 2;
  localparam int FLD_LSB = 5;
  localparam int FLD_MSB = 11;
  localparam int HI_MSB = 8;
  localparam int BIT_XRD = 14;
  localparam int BIT_ERR = 15;
  // Bits that always read as zero.
  localparam logic [15:0] RSV_MASK = 16'h301a;
  // Reset values of the control bits.
  localparam logic EN_RST = 1'b0;
  localparam logic WWP_RST = 1'b0;
  localparam logic ERR_RST = 1'b0;
  localparam logic XRD_RST = 1'b0;
  // Failed address slices of the byte address.
  localparam int FAIL_LO_LSB = 11;
  localparam int FAIL_LO_MSB = 17;
  localparam int FAIL_HI_LSB = 18;
  localparam int FAIL_HI_MSB = 21;
  // A 4 kiloword block starts at byte address bit 13.
  localparam int BLK_LSB = 13;
  // Register slot decode inside the I/O page.
  localparam int IO_OFF_W = 13;
  localparam logic [12:0] REG_IO_BASE = 13'h1440;
  // Size strap sums: low group counts 8 kiloword steps, high group 128 kilowords.
  localparam logic [7:0] SZ_LO_MAX = 8'h0f;
  localparam logic [7:0] SZ_HI_MAX = 8'h03;
  localparam logic [7:0] SZ_HI_UNITS = 8'h10;
  // Byte lane masks.
  localparam logic [15:0] MASK_LO = 16'h00ff;
  localparam logic [15:0] MASK_HI = 16'hff00;
  localparam logic [15:0] MASK_ALL = 16'hffff;
  // Controller states, Gray coded along idle, wait, idle.
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1
  } pcd_state_t;
endpackage

/* File: src/pcd_parity_ctrl.sv */
// Parity control register, memory and register address decode and parity check.
`timescale 1ns/100ps
module pcd_parity_ctrl #(
  parameter int ADDR_W = 22
) (
  // Clock, reset and clock enable.
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Bus request, one-cycle pulses with address and write data.
  input wire logic bus_read,
  input wire logic bus_write,
  input wire logic bus_byte,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic io_page_bank_select,
  // Bus answer: data lines 0 to 17 with their drive enable.
  output logic reply_r,
  output logic [15:0] rdata_r,
  output logic perr16_r,
  output logic perr17_r,
  output logic rdata_oe_r,
  // Straps, high means installed.
  input wire logic register_enable_strap,
  input wire logic register_disable_strap,
  input wire logic parity_inhibit_strap,
  input wire logic [2:0] reg_addr_straps,
  input wire logic [4:0] start_address_straps,
  input wire logic [3:0] ext_start_straps,
  input wire logic [3:0] extended_address_straps,
  input wire logic [3:0] size_lo_straps,
  input wire logic [1:0] size_hi_straps,
  // Memory array port.
  output logic mem_rd_r,
  output logic mem_wr_r,
  output logic [ADDR_W-2:0] mem_addr_r,
  output logic [15:0] mem_wdata_r,
  output logic [1:0] mem_be_r,
  output logic [1:0] mem_wpar_r,
  input wire logic mem_rd_valid,
  input wire logic [15:0] mem_rdata,
  input wire logic [1:0] mem_rpar,
  // Error lamp, lit while the error bit is set.
  output logic parity_led_r
);

  ////////////////////////////////////////////////////////////////////////////
  // Odd parity per byte, so an all-zero byte never looks correct by accident.
  function automatic logic [1:0] byte_par(input logic [15:0] d);
    byte_par = {~^d[15:8], ~^d[7:0]};
  endfunction

  // Control and captured state.
  pcd_pkg::pcd_state_t st_r, st_nxt;
  logic en_r, en_nxt;
  logic wwp_r, wwp_nxt;
  logic xrd_r, xrd_nxt;
  logic err_r, err_nxt;
  logic [6:0] fld_r, fld_nxt;
  logic [3:0] hi_r, hi_nxt;
  logic [ADDR_W-1:0] hold_r, hold_nxt;
  // Output next values.
  logic reply_nxt, oe_nxt, p16_nxt, p17_nxt, mrd_nxt, mwr_nxt;
  logic [15:0] rdata_nxt, mwd_nxt;
  logic [ADDR_W-2:0] maddr_nxt;
  logic [1:0] mbe_nxt, mpar_nxt;
  // Decode terms.
  logic ext_en, mem_hit, reg_hit, perr_now;
  logic [8:0] blk, start_blk;
  logic [9:0] diff;
  logic [7:0] size_blk;
  logic [15:0] rd_val, store_val, wmask, wr_val;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode for memory and for the register slot.
  always_comb begin
    // Without extended addressing the top address bits are not decoded.
    ext_en = |extended_address_straps;
    blk = bus_addr[ADDR_W-1:pcd_pkg::BLK_LSB];
    if (!ext_en) begin
      blk[8:5] = 4'h0;
    end
    // Start block in 4 kiloword units, lowest strap is the lowest bit.
    start_blk = {ext_en ? ext_start_straps : 4'h0, start_address_straps};
    // Size in 4 kiloword blocks, the sum of both strap groups.
    size_blk = 8'((pcd_pkg::SZ_LO_MAX - {4'h0, size_lo_straps} + 8'h01)
      + (pcd_pkg::SZ_HI_MAX - {6'h00, size_hi_straps}) * pcd_pkg::SZ_HI_UNITS) << 1;
    diff = {1'b0, blk} - {1'b0, start_blk};
    // Memory stays off the bus during I/O page cycles.
    mem_hit = !io_page_bank_select && !diff[9] && (diff < {2'b00, size_blk});
    // One of eight word slots, chosen by three straps read inverted.
    reg_hit = io_page_bank_select && register_enable_strap && !register_disable_strap
      && (bus_addr[pcd_pkg::IO_OFF_W-1:0]
      == pcd_pkg::REG_IO_BASE + {9'h000, ~reg_addr_straps, 1'b0});
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read view and write merge.
  always_comb begin
    // Stored image, reserved bits held at zero.
    store_val = 16'h0000;
    store_val[pcd_pkg::BIT_EN] = en_r;
    store_val[pcd_pkg::BIT_WWP] = wwp_r;
    store_val[pcd_pkg::FLD_MSB:pcd_pkg::FLD_LSB] = fld_r;
    store_val[pcd_pkg::BIT_XRD] = xrd_r;
    store_val[pcd_pkg::BIT_ERR] = err_r;
    rd_val = store_val & ~pcd_pkg::RSV_MASK;
    // Extended view replaces the field with the upper failed address.
    if (xrd_r) begin
      rd_val[pcd_pkg::FLD_MSB:pcd_pkg::FLD_LSB] = {3'h0, hi_r};
    end
    // Byte writes touch only their own lane.
    if (!bus_byte) begin
      wmask = pcd_pkg::MASK_ALL;
    end else if (bus_addr[0]) begin
      wmask = pcd_pkg::MASK_HI;
    end else begin
      wmask = pcd_pkg::MASK_LO;
    end
    wr_val = (store_val & ~wmask) | (bus_wdata & wmask);
    // Parity mismatch on either byte of returned data.
    perr_now = |(mem_rpar ^ byte_par(mem_rdata));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state: requests are taken only in idle, memory reads wait for data.
  always_comb begin
    st_nxt = st_r;
    en_nxt = en_r;
    wwp_nxt = wwp_r;
    xrd_nxt = xrd_r;
    err_nxt = err_r;
    fld_nxt = fld_r;
    hi_nxt = hi_r;
    hold_nxt = hold_r;
    reply_nxt = 1'b0;
    oe_nxt = 1'b0;
    p16_nxt = 1'b0;
    p17_nxt = 1'b0;
    rdata_nxt = rdata_r;
    mrd_nxt = 1'b0;
    mwr_nxt = 1'b0;
    maddr_nxt = mem_addr_r;
    mwd_nxt = mem_wdata_r;
    mbe_nxt = mem_be_r;
    mpar_nxt = mem_wpar_r;
    case (st_r)
      pcd_pkg::ST_IDLE: begin
        if (reg_hit && bus_read) begin
          // Register read answers on the next edge.
          reply_nxt = 1'b1;
          oe_nxt = 1'b1;
          rdata_nxt = rd_val;
        end else if (reg_hit && bus_write) begin
          // Reserved positions never reach storage.
          en_nxt = wr_val[pcd_pkg::BIT_EN];
          wwp_nxt = wr_val[pcd_pkg::BIT_WWP];
          fld_nxt = wr_val[pcd_pkg::FLD_MSB:pcd_pkg::FLD_LSB];
          xrd_nxt = wr_val[pcd_pkg::BIT_XRD];
          err_nxt = wr_val[pcd_pkg::BIT_ERR];
          reply_nxt = 1'b1;
        end else if (mem_hit && bus_read) begin
          mrd_nxt = 1'b1;
          maddr_nxt = bus_addr[ADDR_W-1:1];
          hold_nxt = bus_addr;
          st_nxt = pcd_pkg::ST_WAIT;
        end else if (mem_hit && bus_write) begin
          // Parity is made per byte; the force bit inverts both.
          mwr_nxt = 1'b1;
          maddr_nxt = bus_addr[ADDR_W-1:1];
          mwd_nxt = bus_wdata;
          mbe_nxt = {wmask[15], wmask[0]};
          mpar_nxt = byte_par(bus_wdata) ^ {wwp_r, wwp_r};
          reply_nxt = 1'b1;
        end
      end
      pcd_pkg::ST_WAIT: begin
        if (mem_rd_valid) begin
          reply_nxt = 1'b1;
          oe_nxt = 1'b1;
          rdata_nxt = mem_rdata;
          st_nxt = pcd_pkg::ST_IDLE;
          if (perr_now) begin
            // Both address parts come from the same failing access; bits
            // below 11 are dropped, so the result names a 1K segment.
            err_nxt = 1'b1;
            fld_nxt = hold_r[pcd_pkg::FAIL_LO_MSB:pcd_pkg::FAIL_LO_LSB];
            hi_nxt = hold_r[pcd_pkg::FAIL_HI_MSB:pcd_pkg::FAIL_HI_LSB];
            p16_nxt = en_r;
            p17_nxt = en_r && !parity_inhibit_strap;
          end
        end
      end
      default: begin
        st_nxt = pcd_pkg::ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; the address field and backup are data and keep their value
  // through bus initialise, so software can read them after a restart.
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= pcd_pkg::ST_IDLE;
      en_r <= pcd_pkg::EN_RST;
      wwp_r <= pcd_pkg::WWP_RST;
      xrd_r <= pcd_pkg::XRD_RST;
      err_r <= pcd_pkg::ERR_RST;
      reply_r <= 1'b0;
      rdata_oe_r <= 1'b0;
      perr16_r <= 1'b0;
      perr17_r <= 1'b0;
      rdata_r <= 16'h0000;
      mem_rd_r <= 1'b0;
      mem_wr_r <= 1'b0;
      mem_addr_r <= '0;
      mem_wdata_r <= 16'h0000;
      mem_be_r <= 2'h0;
      mem_wpar_r <= 2'h0;
      parity_led_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      en_r <= en_nxt;
      wwp_r <= wwp_nxt;
      xrd_r <= xrd_nxt;
      err_r <= err_nxt;
      reply_r <= reply_nxt;
      rdata_oe_r <= oe_nxt;
      perr16_r <= p16_nxt;
      perr17_r <= p17_nxt;
      rdata_r <= rdata_nxt;
      mem_rd_r <= mrd_nxt;
      mem_wr_r <= mwr_nxt;
      mem_addr_r <= maddr_nxt;
      mem_wdata_r <= mwd_nxt;
      mem_be_r <= mbe_nxt;
      mem_wpar_r <= mpar_nxt;
      parity_led_r <= err_nxt;
    end
  end

  // Data registers without reset.
  always_ff @(posedge clk) begin
    if (ce) begin
      fld_r <= fld_nxt;
      hi_r <= hi_nxt;
      hold_r <= hold_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_bad_read;
    ce && st_r == pcd_pkg::ST_WAIT && mem_rd_valid && perr_now;
  endsequence

  property p_rsv_zero;
    reply_r && rdata_oe_r && $past(reg_hit) |-> (rdata_r & pcd_pkg::RSV_MASK) == 16'h0000;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits read nonzero");

  property p_line16;
    s_bad_read |=> reply_r && rdata_oe_r && perr16_r == $past(en_r);
  endproperty
  a_line16: assert property (p_line16) else $error("line 16 wrong on parity error");

  property p_force_par;
    ce && st_r == pcd_pkg::ST_IDLE && mem_hit && bus_write && !bus_read && !reg_hit && wwp_r
      |=> mem_wr_r && mem_wpar_r == ~byte_par($past(bus_wdata));
  endproperty
  a_force_par: assert property (p_force_par) else $error("forced parity not inverted");

  property p_init_clear;
    @(posedge clk) disable iff (1'b0) reset |=> !en_r && !wwp_r && !err_r && !reply_r;
  endproperty
  a_init_clear: assert property (p_init_clear) else $error("control bits not cleared");

  property p_capture;
    s_bad_read |=> err_r
      && fld_r == $past(hold_r[pcd_pkg::FAIL_LO_MSB:pcd_pkg::FAIL_LO_LSB])
      && hi_r == $past(hold_r[pcd_pkg::FAIL_HI_MSB:pcd_pkg::FAIL_HI_LSB]);
  endproperty
  a_capture: assert property (p_capture) else $error("failed address not captured");

  // Checked on the answer itself against hi_r, so a broken read mux shows up here; capture is left to a_capture.
  property p_ext_view;
    reply_r && rdata_oe_r && $past(reg_hit && xrd_r)
      |-> rdata_r[pcd_pkg::FLD_MSB:pcd_pkg::FLD_LSB] == {3'h0, $past(hi_r)};
  endproperty
  a_ext_view: assert property (p_ext_view) else $error("extended view wrong");

  property p_inhibit;
    parity_inhibit_strap && $past(parity_inhibit_strap) |-> !perr17_r;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("line 17 driven while inhibited");

  property p_reg_off;
    ce && st_r == pcd_pkg::ST_IDLE && io_page_bank_select && bus_read
      && (!register_enable_strap || register_disable_strap) |=> !reply_r;
  endproperty
  a_reg_off: assert property (p_reg_off) else $error("disabled register answered");

  property p_bank_sel;
    ce && st_r == pcd_pkg::ST_IDLE && io_page_bank_select && (bus_read || bus_write)
      |=> !mem_rd_r && !mem_wr_r;
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("memory selected in I/O page");

endmodule

/* File: verification/pcd_mem_model.sv */
// Behavioural memory array answering the block's memory port.
`timescale 1ns/100ps
module pcd_mem_model (
  // Clock.
  input wire logic clk,
  // Requests from the block.
  input wire logic rd,
  input wire logic wr,
  input wire logic [20:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [1:0] be,
  input wire logic [1:0] wpar,
  // Read answer.
  output logic rd_valid,
  output logic [15:0] rdata,
  output logic [1:0] rpar
);
  // Each word keeps its two parity bits above the data.
  logic [17:0] mem [int];
  logic [17:0] w;
  initial begin
    rd_valid = 1'b0;
    rdata = 16'h0000;
    rpar = 2'h0;
  end
  //////////////////////////////////////////////////////////////////////
  // Writes merge per lane and parity is stored as given, so a forced bad bit survives.
  // Reads answer after one to three cycles; requests during that wait are not seen.
  always @(posedge clk) begin
    rd_valid <= 1'b0;
    rdata <= ~rdata;  // Outside the read wait the data lines invert each cycle, so they show the last word every other cycle.
    if (wr === 1'b1) begin
      w = mem.exists(addr) ? mem[addr] : 18'h00000;
      if (be[0]) w = {w[17], wpar[0], w[15:8], wdata[7:0]};
      if (be[1]) w = {wpar[1], w[16], wdata[15:8], w[7:0]};
      mem[addr] = w;
    end
    if (rd === 1'b1) begin
      w = mem.exists(addr) ? mem[addr] : 18'h00000;
      repeat ($urandom_range(3, 1)) @(posedge clk);
      rd_valid <= 1'b1;
      rdata <= w[15:0];
      rpar <= w[17:16];
    end
  end
endmodule

/* File: verification/tb.sv */
// Self-checking testbench for the parity control register and decode block.
`timescale 1ns/100ps
module tb;
  logic clk, reset, bus_read, bus_write, bus_byte, bank;
  logic [21:0] bus_addr, a, b, c;
  logic [15:0] bus_wdata, d, d1, d2;
  logic reply_r, perr16_r, perr17_r, rdata_oe_r, mem_rd_r, mem_wr_r, rd_valid;
  logic [15:0] rdata_r, mem_wdata_r, mem_rdata;
  logic [20:0] mem_addr_r;
  logic [1:0] mem_be_r, mem_wpar_r, mem_rpar, size_hi;
  logic en_s, dis_s, inh_s, parity_led_r;
  logic [2:0] slot_s;
  logic [4:0] start_s;
  logic [3:0] size_lo, ext_s, xst_s;
  int bad_count, num_checks, seed_v;
  logic [17:0] exp_q [$];
  logic [17:0] e;
  localparam logic [21:0] RA = 22'h001440;
  //////////////////////////////////////////////////////////////////////
  // Straps stay variables so each scenario can re-strap the board.
  pcd_parity_ctrl uut (.clk(clk), .reset(reset), .ce(1'b1), .bus_read(bus_read),
    .bus_write(bus_write), .bus_byte(bus_byte), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .io_page_bank_select(bank), .reply_r(reply_r), .rdata_r(rdata_r), .perr16_r(perr16_r),
    .perr17_r(perr17_r), .rdata_oe_r(rdata_oe_r), .register_enable_strap(en_s),
    .register_disable_strap(dis_s), .parity_inhibit_strap(inh_s), .reg_addr_straps(slot_s),
    .start_address_straps(start_s), .ext_start_straps(xst_s), .extended_address_straps(ext_s),
    .size_lo_straps(size_lo), .size_hi_straps(size_hi), .mem_rd_r(mem_rd_r),
    .mem_wr_r(mem_wr_r), .mem_addr_r(mem_addr_r), .mem_wdata_r(mem_wdata_r),
    .mem_be_r(mem_be_r), .mem_wpar_r(mem_wpar_r), .mem_rd_valid(rd_valid),
    .mem_rdata(mem_rdata), .mem_rpar(mem_rpar), .parity_led_r(parity_led_r));
  pcd_mem_model mem (.clk(clk), .rd(mem_rd_r), .wr(mem_wr_r), .addr(mem_addr_r),
    .wdata(mem_wdata_r), .be(mem_be_r), .wpar(mem_wpar_r), .rd_valid(rd_valid),
    .rdata(mem_rdata), .rpar(mem_rpar));
  //////////////////////////////////////////////////////////////////////
  // Clock at 50 MHz.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Compare and count.
  task automatic chk(input string what, input logic [17:0] ex, input logic [17:0] got);
    num_checks++;
    if (ex !== got) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, ex, got);
    end
  endtask
  // Print the counts and the verdict, then stop.
  task automatic conclude();
    $display("Counts: %0d mismatches in %0d checks", bad_count, num_checks);
    if (bad_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Every read answer is matched against the oldest expectation.
  always @(negedge clk) begin
    if (rdata_oe_r === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected answer", 18'h00000, {perr17_r, perr16_r, rdata_r});
      else begin
        e = exp_q.pop_front();
        chk("read answer", e, {perr17_r, perr16_r, rdata_r});
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // One request pulse; then a bounded wait for the reply, which must or must not come.
  task automatic req(input logic r, input logic w, input logic byt, input logic [21:0] ad,
      input logic [15:0] dat, input logic bk, input logic want);
    int n;
    @(negedge clk);
    bus_read = r;
    bus_write = w;
    bus_byte = byt;
    bus_addr = ad;
    bus_wdata = dat;
    bank = bk;
    @(negedge clk);
    bus_read = 1'b0;
    bus_write = 1'b0;
    n = 0;
    while (reply_r !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("reply", {17'h0, want}, {17'h0, n < 20});
    if (want && n >= 20) conclude();
  endtask
  task automatic wreg(input logic [15:0] v);
    req(1'b0, 1'b1, 1'b0, RA, v, 1'b1, 1'b1);
  endtask
  task automatic rreg(input logic [21:0] ad, input logic [15:0] v);
    exp_q.push_back({2'b00, v});
    req(1'b1, 1'b0, 1'b0, ad, 16'h0000, 1'b1, 1'b1);
  endtask
  task automatic rmem(input logic [21:0] ad, input logic [15:0] v, input logic [1:0] p);
    exp_q.push_back({p, v});
    req(1'b1, 1'b0, 1'b0, ad, 16'h0000, 1'b0, 1'b1);
  endtask
  //////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    seed_v = $urandom(32'hf28f);
    {reset, bus_read, bus_write, bus_byte, bank} = 5'b10000;
    {bus_addr, bus_wdata} = '0;
    {en_s, dis_s, inh_s, slot_s, start_s, size_lo, size_hi} = {3'b100, 3'b111, 5'h00, 6'h03};
    {ext_s, xst_s} = 8'h00;
    bad_count = 0;
    num_checks = 0;
    repeat (16) @(negedge clk);
    reset = 1'b0;
    wreg(16'hbfff);
    rreg(RA, 16'h8fe5);
    @(negedge clk) reset = 1'b1;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    rreg(RA, 16'h0fe0);
    for (int i = 0; i < 4; i++) begin
      d = 16'($urandom) & 16'hbfff;
      wreg(d);
      rreg(RA, d & 16'h8fe5);
    end
    wreg(16'h0001);
    a = {4'h0, 18'($urandom) & 18'h1fffe};
    d = 16'($urandom);
    req(1'b0, 1'b1, 1'b0, a, d, 1'b0, 1'b1);
    rmem(a, d, 2'b00);
    d1 = {2{8'($urandom)}};
    req(1'b0, 1'b1, 1'b1, a | 22'h1, d1, 1'b0, 1'b1);
    rmem(a, {d1[15:8], d[7:0]}, 2'b00);
    b = 22'h29a2b4;
    c = 22'h16c3d6;
    d1 = 16'($urandom);
    d2 = 16'($urandom);
    wreg(16'h0005);
    req(1'b0, 1'b1, 1'b0, b, d1, 1'b0, 1'b1);
    req(1'b0, 1'b1, 1'b0, c, d2, 1'b0, 1'b1);
    wreg(16'h0001);
    rmem(b, d1, 2'b11);
    rreg(RA, 16'h8001 | {4'h0, b[17:11], 5'h00});
    chk("error lamp", 18'h1, {17'h0, parity_led_r});
    wreg(16'hc001 | {4'h0, b[17:11], 5'h00});
    rreg(RA, 16'hc001 | {7'h00, b[21:18], 5'h00});
    wreg(16'h8001);
    inh_s = 1'b1;
    rmem(c, d2, 2'b01);
    rreg(RA, 16'h8001 | {4'h0, c[17:11], 5'h00});
    wreg(16'h0000);
    inh_s = 1'b0;
    rmem(b, d1, 2'b00);
    rreg(RA, 16'h8000 | {4'h0, b[17:11], 5'h00});
    req(1'b1, 1'b0, 1'b0, RA | 22'h2, 16'h0000, 1'b1, 1'b0);
    slot_s = 3'b110;
    rreg(RA | 22'h2, 16'h8000 | {4'h0, b[17:11], 5'h00});
    slot_s = 3'b111;
    dis_s = 1'b1;
    req(1'b1, 1'b0, 1'b0, RA, 16'h0000, 1'b1, 1'b0);
    dis_s = 1'b0;
    start_s = 5'h01;
    req(1'b1, 1'b0, 1'b0, 22'h000000, 16'h0000, 1'b0, 1'b0);
    req(1'b0, 1'b1, 1'b0, 22'h002000, d, 1'b0, 1'b1);
    start_s = 5'h00;
    size_lo = 4'hf;
    req(1'b0, 1'b1, 1'b0, 22'h004000, d, 1'b0, 1'b0);
    req(1'b0, 1'b1, 1'b0, 22'h003ffe, d, 1'b0, 1'b1);
    // Extended addressing on: memory moves to the second 128 kiloword bank.
    ext_s = 4'hf;
    xst_s = 4'h1;
    size_lo = 4'h0;
    req(1'b0, 1'b1, 1'b0, 22'h040000, d, 1'b0, 1'b1);
    req(1'b0, 1'b1, 1'b0, 22'h000000, d, 1'b0, 1'b0);
    rmem(22'h040000, d, 2'b00);
    {ext_s, xst_s} = 8'h00;
    // A forced byte write spoils only the high lane's parity bit.
    wreg(16'h0005);
    req(1'b0, 1'b1, 1'b1, a | 22'h1, d2, 1'b0, 1'b1);
    rmem(a, {d2[15:8], d[7:0]}, 2'b11);
    repeat (4) @(negedge clk);
    chk("answers left", 18'h0, 18'(exp_q.size()));
    conclude();
  end
endmodule
